//--- tb_top.sv
// Self-checking bench for the three-stage overvoltage top
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import tsov_pkg::*;
	localparam int TICK = 10;
	localparam int PER  = 4;
	logic              clk    = 1'b0;
	logic              rst_n  = 1'b0;
	logic [9:2]        adr    = '0;
	logic [31:0]       wdat   = '0;
	logic              we     = 1'b0;
	logic              cyc    = 1'b0;
	logic              stb    = 1'b0;
	logic [1:0]        grp    = '0;
	logic [VOLT_W-1:0] tab    = '0;
	logic [VOLT_W-1:0] tbc    = '0;
	logic [VOLT_W-1:0] tca    = '0;
	logic [31:0]       rng    = 32'h63;
	logic [31:0]       rdat, q;
	logic              ack, vvalid, irq;
	logic [VOLT_W-1:0] vab, vbc, vca, v, lvl;
	logic [2:0]        start, trip;
	logic [15:0]       rv  [4] = '{THR_DEF, 16'h001E, OP_DEF, REL_DEF};
	logic [31:0]       thr [3] = '{32'h03E8, 32'h07D0, 32'h0BB8};
	logic [7:0]        um  [3] = '{8'h13, 8'h30, 8'h50};
	int                n_errors = 0;
	int                n_compared = 0;
	int                c;
	int                t0;
	int                now_cyc = 0;
	logic [3:0]        sel    = 4'hF;
	logic [3:0]        wsel   = 4'hF;

	always #5 clk = ~clk;

	// Free cycle count, so delays can be timed from an earlier event
	always @(posedge clk) now_cyc <= now_cyc + 1;

	tsov_front_model #(.PERIOD(PER)) i_tsov_front_model (.clk_i(clk), .rst_n_i(rst_n),
		.ab_i(tab), .bc_i(tbc), .ca_i(tca), .ab_o(vab), .bc_o(vbc), .ca_o(vca), .valid_o(vvalid));
	tsov_top #(.TICK_CYCLES(TICK)) i_tsov_top (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_ADR_I(adr),
		.WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .VOLT_AB_I(vab), .VOLT_BC_I(vbc), .VOLT_CA_I(vca),
		.VOLT_VALID_I(vvalid), .GROUP_SEL_I(grp), .START_O(start), .TRIP_O(trip), .IRQ_O(irq));

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [7:0] idx(input int s, input int g, input int f);
		return 8'(s * 16 + g * 4 + f);
	endfunction : idx

	function automatic logic [15:0] exp_set(input int s, input int f, input logic [15:0] x);
		logic [15:0] lo, hi;
		lo = 16'h0000;
		hi = 16'hFFFF;
		if (f == 1) begin
			lo = {8'h00, HYST_MIN};
			hi = {8'h00, HYST_MAX};
		end else if (f == 2) begin
			lo = s == 0 ? OP_MIN_S0 : s == 1 ? OP_MIN_S1 : OP_MIN_S2;
			hi = OP_MAX;
		end else if (f == 3) begin
			lo = REL_MIN;
			hi = REL_MAX;
		end
		return x < lo ? lo : x > hi ? hi : x;
	endfunction : exp_set

	function automatic logic [15:0] rel_lvl(input int t, input int h);
		return 16'(t * (1000 - h) / 1000);
	endfunction : rel_lvl

	function automatic logic win(input int n, input int op);
		return n >= op * TICK - 2 && n <= (op + 1) * TICK + 2;
	endfunction : win

	function automatic logic pick(input int kind, input int i);
		return kind == 0 ? start[i] : kind == 1 ? trip[i] : irq;
	endfunction : pick

	task automatic conclude();
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
		n_compared++;
		if (seen !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, seen);
		end
	endtask : check

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= wsel;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			check("wb ack", 32'h0, 32'h1);
			conclude();
		end
	endtask : wb

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		wb(a, 1'b0, 32'h0);
		check(what, q & m, e);
	endtask : rd_chk

	task automatic set_v(input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
		@(posedge clk);
		tab <= a;
		tbc <= b;
		tca <= d;
	endtask : set_v

	// Bounded wait for an output level; running out ends the run
	task automatic wait_out(input string what, input int kind, input int i, input logic val);
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (pick(kind, i) !== val && c < 400);
		if (c >= 400) begin
			check(what, 32'h0, 32'h1);
			conclude();
		end
	endtask : wait_out

	// --------------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int f = 0; f < 4; f++)
			rd_chk("reset setting", idx(0, 0, f), {16'h0, rv[f]}, 32'hFFFF);
		for (int s = 0; s < 3; s++)
			for (int g = 0; g < 4; g++)
				for (int f = 1; f < 4; f++)
					for (int k = 0; k < 3; k++) begin
						if (f == 3 && s > 0)
							continue;
						rng = xs(rng);
						v = rng[15:0] & (f == 1 ? 16'h00FF : 16'hFFFE);
						v = k == 0 ? 16'h0000 : k == 2 ? 16'hFFFF : v;
						wb(idx(s, g, f), 1'b1, {16'h0, v});
						rd_chk("setting", idx(s, g, f), {16'h0, exp_set(s, f, v)}, 32'hFFFF);
					end
		// Low byte lane only: upper byte of the threshold must survive
		wsel = 4'h1;
		wb(idx(0, 2, 0), 1'b1, 32'h0000ABCD);
		wsel = 4'hF;
		rd_chk("byte lane", idx(0, 2, 0), 32'hFFCD, 32'hFFFF);
		foreach (um[i]) begin
			wb(um[i], 1'b1, 32'h1234);
			rd_chk("unmapped", um[i], 32'h0, 32'hFFFFFFFF);
		end
		for (int s = 0; s < 3; s++) begin
			wb(idx(s, 0, 0), 1'b1, thr[s]);
			wb(idx(s, 0, 1), 1'b1, 32'h1E);
			wb(idx(s, 0, 2), 1'b1, 32'(8 - 2 * s));
		end
		wb(idx(0, 0, 3), 1'b1, 32'h3);
		set_v(16'h0000, 16'h05DC, 16'h0000);
		wait_out("start0", 0, 0, 1'b1);
		t0 = now_cyc;
		repeat (2 * PER) @(posedge clk);
		check("start set", start, 3'b001);
		rd_chk("status", IDX_STATUS, 32'h01, 32'h3F);
		check("irq masked", irq, 1'b0);
		wb(IDX_MASK, 1'b1, 32'h3F);
		wait_out("irq", 2, 0, 1'b1);
		wait_out("trip0", 1, 0, 1'b1);
		check("op time", win(now_cyc - t0, 8), 1'b1);
		rd_chk("status", IDX_STATUS, 32'h09, 32'h3F);
		rd_chk("state", IDX_STATE, 32'h09, 32'hFF);
		wb(IDX_STATUS, 1'b1, 32'h3F);
		wait_out("irq clear", 2, 0, 1'b0);
		set_v(16'h0000, 16'h0000, 16'h0000);
		wait_out("release0", 0, 0, 1'b0);
		check("hold trip", trip[0], 1'b0);
		repeat (2 * TICK) @(posedge clk);
		set_v(16'h0000, 16'h05DC, 16'h0000);
		wait_out("resume", 1, 0, 1'b1);
		check("resume fast", c <= PER + 5, 1'b1);
		set_v(16'h0000, 16'h0000, 16'h0000);
		// Longer than six ticks of release delay plus latency
		repeat (10 * TICK) @(posedge clk);
		set_v(16'h0000, 16'h05DC, 16'h0000);
		wait_out("restart0", 0, 0, 1'b1);
		wait_out("trip0 again", 1, 0, 1'b1);
		check("cleared time", win(c, 8), 1'b1);
		lvl = rel_lvl(3000, 30);
		set_v(16'h0C1C, 16'h0000, 16'h0000);
		wait_out("start2", 0, 2, 1'b1);
		wait_out("trip2", 1, 2, 1'b1);
		check("stage3 time", win(c, 4), 1'b1);
		for (int i = 0; i < 3; i++)
			rd_chk("volt", 8'(IDX_VOLT_AB + i), i == 0 ? 32'h0C1C : 32'h0, 32'hFFFF);
		set_v(lvl + 16'h0028, 16'h0000, 16'h0000);
		repeat (3 * PER) @(posedge clk);
		check("band", start[2], 1'b1);
		set_v(lvl - 16'h000A, 16'h0000, 16'h0000);
		wait_out("release2", 0, 2, 1'b0);
		check("drop fast", c <= PER + 4 && trip[2] === 1'b0, 1'b1);
		set_v(16'h0C1C, 16'h0000, 16'h0000);
		wait_out("start2 b", 0, 2, 1'b1);
		wait_out("trip2 b", 1, 2, 1'b1);
		check("counter cleared", win(c, 4), 1'b1);
		set_v(16'h0000, 16'h0000, 16'h0000);
		wb(idx(0, 1, 0), 1'b1, 32'h01F4);
		set_v(16'h02BC, 16'h0000, 16'h0000);
		repeat (3 * PER) @(posedge clk);
		check("group0", start, 3'b000);
		grp <= 2'h1;
		wait_out("group1", 0, 0, 1'b1);
		check("group delay", c <= PER + 6, 1'b1);
		rd_chk("state group", IDX_STATE, 32'h41, 32'hC7);
		conclude();
	end
endmodule : tb_top
`default_nettype wire

//--- tsov_asserts.sv
// Concurrent checks on the overvoltage top ports
`timescale 1ns/10ps
`default_nettype none
module tsov_asserts
	import tsov_pkg::*;
#(
	parameter int TICK_CYCLES = 10
) (
	input wire logic        CLOCK_I,
	input wire logic        RST_N_I,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        VOLT_VALID_I,
	input wire logic [2:0]  START_O,
	input wire logic [2:0]  TRIP_O,
	input wire logic        IRQ_O
);
	// Minimum started time before a trip, with two cycles of slack
	localparam int MIN1 = 6 * TICK_CYCLES - 2;
	localparam int MIN2 = 4 * TICK_CYCLES - 2;
	logic [15:0] on_cnt [3];

	always_ff @(posedge CLOCK_I) begin
		for (int k = 0; k < 3; k++) begin
			if (!RST_N_I || !START_O[k])
				on_cnt[k] <= 16'h0000;
			else if (on_cnt[k] != 16'hFFFF)
				on_cnt[k] <= on_cnt[k] + 16'h0001;
		end
	end

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);

	ack_answer_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
		else $error("ack without request");
	read_hold_a: assert property ($changed(WB_DAT_O) |-> $rose(WB_ACK_O))
		else $error("read data moved outside an answer");
	reset_quiet_a: assert property (disable iff (1'b0)
		!RST_N_I |=> (START_O == 3'h0 && TRIP_O == 3'h0 && !IRQ_O && !WB_ACK_O))
		else $error("outputs active after reset");
	start_eval_a: assert property ((START_O & ~$past(START_O)) != 3'h0 |-> $past(VOLT_VALID_I, 2))
		else $error("start rose without evaluation");
	release_eval_a: assert property ((~START_O & $past(START_O)) != 3'h0 |-> $past(VOLT_VALID_I, 2))
		else $error("start fell without evaluation");
	trip_started_a: assert property ((TRIP_O & ~START_O) == 3'h0)
		else $error("trip without start");
	trip_floor1_a: assert property ($rose(TRIP_O[1]) |-> on_cnt[1] >= MIN1)
		else $error("stage two tripped early");
	trip_floor2_a: assert property ($rose(TRIP_O[2]) |-> on_cnt[2] >= MIN2)
		else $error("stage three tripped early");
endmodule : tsov_asserts

bind tsov_top tsov_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_tsov_asserts (
	.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .VOLT_VALID_I(VOLT_VALID_I),
	.START_O(START_O), .TRIP_O(TRIP_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- tsov_front_model.sv
// Voltage front end model: magnitudes with a periodic evaluation strobe
`timescale 1ns/10ps
`default_nettype none
module tsov_front_model
	import tsov_pkg::*;
#(
	parameter int PERIOD = 4
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [VOLT_W-1:0] ab_i,
	input  wire logic [VOLT_W-1:0] bc_i,
	input  wire logic [VOLT_W-1:0] ca_i,
	output logic      [VOLT_W-1:0] ab_o,
	output logic      [VOLT_W-1:0] bc_o,
	output logic      [VOLT_W-1:0] ca_o,
	output logic                   valid_o
);
	int unsigned phase;
	logic        due;

	assign due = (phase == PERIOD - 1);

	// Lines flip between strobes, so a late sample reads junk
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase   <= '0;
			valid_o <= 1'b0;
			ab_o    <= '0;
			bc_o    <= '0;
			ca_o    <= '0;
		end else begin
			phase   <= due ? '0 : phase + 1;
			valid_o <= due;
			ab_o    <= due ? ab_i : ~ab_o;
			bc_o    <= due ? bc_i : ~bc_o;
			ca_o    <= due ? ca_i : ~ca_o;
		end
	end
endmodule : tsov_front_model
`default_nettype wire

//--- tsov_pkg.sv
// Constants, register map and types for the three-stage overvoltage protection
`default_nettype none
package tsov_pkg;

	// --------------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------------
	localparam int CLK_FREQ_MHZ    = 100;
	localparam int TICK_TIME_US    = 10000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_US * CLK_FREQ_MHZ;

	// --------------------------------------------------------------------
	// Structure
	// --------------------------------------------------------------------
	localparam int NUM_STAGES = 3;
	localparam int NUM_GROUPS = 4;
	localparam int NUM_SETS   = NUM_STAGES * NUM_GROUPS;
	localparam int VOLT_W     = 16;
	localparam int CNT_W      = 16;

	// --------------------------------------------------------------------
	// Setting limits and reset values
	// --------------------------------------------------------------------
	localparam logic [9:0]  HYST_SCALE = 10'h3E8;
	localparam logic [7:0]  HYST_DEF   = 8'h1E;
	localparam logic [7:0]  HYST_MIN   = 8'h01;
	localparam logic [7:0]  HYST_MAX   = 8'hC8;
	localparam logic [15:0] THR_DEF    = 16'hFFFF;
	localparam logic [15:0] OP_DEF     = 16'h0008;
	localparam logic [15:0] OP_MAX     = 16'h7530;
	localparam logic [15:0] OP_MIN_S0  = 16'h0008;
	localparam logic [15:0] OP_MIN_S1  = 16'h0006;
	localparam logic [15:0] OP_MIN_S2  = 16'h0004;
	localparam logic [15:0] REL_DEF    = 16'h0003;
	localparam logic [15:0] REL_MIN    = 16'h0003;
	localparam logic [15:0] REL_MAX    = 16'h3A98;

	// --------------------------------------------------------------------
	// Register map (word index, byte address is four times it)
	// --------------------------------------------------------------------
	localparam logic [1:0] FLD_THR  = 2'h0;
	localparam logic [1:0] FLD_HYST = 2'h1;
	localparam logic [1:0] FLD_OP   = 2'h2;
	localparam logic [1:0] FLD_REL  = 2'h3;
	localparam logic [1:0] STAGE_NONE = 2'h3;
	localparam logic [7:0] IDX_STATUS  = 8'h40;
	localparam logic [7:0] IDX_MASK    = 8'h41;
	localparam logic [7:0] IDX_STATE   = 8'h42;
	localparam logic [7:0] IDX_VOLT_AB = 8'h43;
	localparam logic [7:0] IDX_VOLT_BC = 8'h44;
	localparam logic [7:0] IDX_VOLT_CA = 8'h45;

	// Status, mask and state layout
	localparam int EVT_W           = 6;
	localparam int STAT_START_LSB  = 0;
	localparam int STAT_TRIP_LSB   = 3;
	localparam int STATE_GROUP_LSB = 6;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RUN  = 4'h2,
		ST_TRIP = 4'h4,
		ST_HOLD = 4'h8
	} tsov_state_e;

endpackage : tsov_pkg
`default_nettype wire

//--- tsov_stage.sv
// One definite-time overvoltage stage with hysteresis and optional release delay
`default_nettype none
`timescale 1ns/10ps
module tsov_stage
	import tsov_pkg::*;
#(
	parameter bit HAS_RELEASE = 1'b0
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              eval_i,
	input  wire logic              tick_i,
	input  wire logic [VOLT_W-1:0] v_ab_i,
	input  wire logic [VOLT_W-1:0] v_bc_i,
	input  wire logic [VOLT_W-1:0] v_ca_i,
	input  wire logic [15:0]       thr_i,
	input  wire logic [7:0]        hyst_i,
	input  wire logic [15:0]       op_i,
	input  wire logic [15:0]       rel_i,
	output logic                   start_o,
	output logic                   trip_o
);

	tsov_state_e      state;
	logic             fault;
	logic [CNT_W-1:0] op_cnt;
	logic [CNT_W-1:0] rel_cnt;
	logic             next_fault;
	logic             over;
	logic             held;

	// --------------------------------------------------------------------
	// Fault detection
	// --------------------------------------------------------------------
	function automatic logic above_release(input logic [15:0] v, input logic [15:0] thr,
	                                       input logic [7:0] hyst);
		logic [25:0] lhs;
		logic [25:0] rhs;
		lhs = 26'(v) * 26'(HYST_SCALE);
		rhs = 26'(thr) * 26'(HYST_SCALE - 10'(hyst));
		return lhs >= rhs;
	endfunction : above_release

	always_comb begin
		over = (v_ab_i > thr_i) || (v_bc_i > thr_i) || (v_ca_i > thr_i);
		held = above_release(v_ab_i, thr_i, hyst_i) || above_release(v_bc_i, thr_i, hyst_i)
			|| above_release(v_ca_i, thr_i, hyst_i);
		next_fault = fault ? held : over;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fault <= 1'b0;
		end else if (eval_i) begin
			fault <= next_fault;
		end
	end

	// --------------------------------------------------------------------
	// Timing state machine
	// --------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (fault) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!fault) begin
						state <= HAS_RELEASE ? ST_HOLD : ST_IDLE;
					end else if (op_cnt > op_i) begin
						state <= ST_TRIP;
					end
				end
				ST_TRIP: begin
					if (!fault) begin
						state <= HAS_RELEASE ? ST_HOLD : ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (fault) begin
						state <= ST_RUN;
					end else if (rel_cnt >= {rel_i[14:0], 1'b0}) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Operate counter is kept through HOLD so a returning fault resumes it
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			op_cnt <= '0;
		end else if (state == ST_IDLE) begin
			op_cnt <= '0;
		end else if (tick_i && state != ST_HOLD && op_cnt != {CNT_W{1'b1}}) begin
			op_cnt <= op_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rel_cnt <= '0;
		end else if (state != ST_HOLD) begin
			rel_cnt <= '0;
		end else if (tick_i && rel_cnt != {CNT_W{1'b1}}) begin
			rel_cnt <= rel_cnt + 16'h0001;
		end
	end

	assign start_o = (state == ST_RUN) || (state == ST_TRIP);
	assign trip_o  = (state == ST_TRIP);

endmodule : tsov_stage
`default_nettype wire

//--- tsov_top.sv
// Three-stage overvoltage protection with Wishbone settings and interrupt
//
// Function
// - Use only fundamental line-to-line voltage magnitudes
// - Start when any voltage exceeds threshold
// - Trip when fault outlasts operate delay
// - Three independent fixed delay characteristic stages
// - Stage one keeps counter until release delay
// - Returning fault resumes held stage one counter
// - Default three percent hysteresis on release
// - Four setting groups per stage
// - Release delay 0.06 to 300 s, 0.02 steps
// - Hysteresis 0.1 to 20 percent, 0.1 steps
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`default_nettype none
`timescale 1ns/10ps
module tsov_top
	import tsov_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input  wire logic              CLOCK_I,
	input  wire logic              RST_N_I,
	input  wire logic [9:2]        WB_ADR_I,
	input  wire logic [31:0]       WB_DAT_I,
	input  wire logic [3:0]        WB_SEL_I,
	input  wire logic              WB_WE_I,
	input  wire logic              WB_CYC_I,
	input  wire logic              WB_STB_I,
	output logic [31:0]            WB_DAT_O,
	output logic                   WB_ACK_O,
	input  wire logic [VOLT_W-1:0] VOLT_AB_I,
	input  wire logic [VOLT_W-1:0] VOLT_BC_I,
	input  wire logic [VOLT_W-1:0] VOLT_CA_I,
	input  wire logic              VOLT_VALID_I,
	input  wire logic [1:0]        GROUP_SEL_I,
	output logic [NUM_STAGES-1:0]  START_O,
	output logic [NUM_STAGES-1:0]  TRIP_O,
	output logic                   IRQ_O
);

	logic [1:0]            grp_meta;
	logic [1:0]            grp_sync;
	logic [31:0]           tick_cnt;
	logic                  tick;
	logic [VOLT_W-1:0]     volt_ab;
	logic [VOLT_W-1:0]     volt_bc;
	logic [VOLT_W-1:0]     volt_ca;
	logic [15:0]           thr_mem  [NUM_SETS];
	logic [7:0]            hyst_mem [NUM_SETS];
	logic [15:0]           op_mem   [NUM_SETS];
	logic [15:0]           rel_mem  [NUM_GROUPS];
	logic [EVT_W-1:0]      status;
	logic [EVT_W-1:0]      mask;
	logic [NUM_STAGES-1:0] start_prev;
	logic [NUM_STAGES-1:0] trip_prev;
	logic [NUM_STAGES-1:0] start_w;
	logic [NUM_STAGES-1:0] trip_w;
	logic [EVT_W-1:0]      evt;
	logic [EVT_W-1:0]      clr;
	logic [31:0]           rdata;
	logic                  wb_req;
	logic                  wr_fire;
	logic [7:0]            idx;
	logic [1:0]            reg_stage;
	logic [1:0]            reg_group;
	logic [1:0]            reg_field;
	logic                  in_set;
	logic [3:0]            reg_set;

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	function automatic logic [3:0] set_idx(input logic [1:0] stage, input logic [1:0] group);
		return {stage, group};
	endfunction : set_idx

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
	                                        input logic [3:0] sel);
		logic [15:0] m;
		m = old;
		if (sel[0]) begin
			m[7:0] = d[7:0];
		end
		if (sel[1]) begin
			m[15:8] = d[15:8];
		end
		return m;
	endfunction : merge16

	function automatic logic [7:0] clamp_hyst(input logic [15:0] v);
		logic [7:0] r;
		r = v[7:0];
		if (v < 16'(HYST_MIN)) begin
			r = HYST_MIN;
		end else if (v > 16'(HYST_MAX)) begin
			r = HYST_MAX;
		end
		return r;
	endfunction : clamp_hyst

	// Stages one and two step in 20 ms, stage three in 10 ms
	function automatic logic [15:0] clamp_op(input logic [15:0] v, input logic [1:0] stage);
		logic [15:0] lo;
		logic [15:0] r;
		lo = (stage == 2'h0) ? OP_MIN_S0 : ((stage == 2'h1) ? OP_MIN_S1 : OP_MIN_S2);
		r = v;
		if (stage != 2'h2) begin
			r[0] = 1'b0;
		end
		if (r < lo) begin
			r = lo;
		end else if (r > OP_MAX) begin
			r = OP_MAX;
		end
		return r;
	endfunction : clamp_op

	function automatic logic [15:0] clamp_rel(input logic [15:0] v);
		logic [15:0] r;
		r = v;
		if (v < REL_MIN) begin
			r = REL_MIN;
		end else if (v > REL_MAX) begin
			r = REL_MAX;
		end
		return r;
	endfunction : clamp_rel

	// --------------------------------------------------------------------
	// Group select synchroniser and time base
	// --------------------------------------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			grp_meta <= 2'h0;
			grp_sync <= 2'h0;
		end else begin
			grp_meta <= GROUP_SEL_I;
			grp_sync <= grp_meta;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			tick_cnt <= 32'h0;
		end else if (tick) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// Last sampled magnitudes, for software readback only
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			volt_ab <= '0;
			volt_bc <= '0;
			volt_ca <= '0;
		end else if (VOLT_VALID_I) begin
			volt_ab <= VOLT_AB_I;
			volt_bc <= VOLT_BC_I;
			volt_ca <= VOLT_CA_I;
		end
	end

	// --------------------------------------------------------------------
	// Wishbone decode
	// --------------------------------------------------------------------
	assign wb_req    = WB_CYC_I && WB_STB_I;
	assign wr_fire   = wb_req && WB_WE_I && WB_ACK_O;
	assign idx       = WB_ADR_I;
	assign reg_stage = idx[5:4];
	assign reg_group = idx[3:2];
	assign reg_field = idx[1:0];
	assign in_set    = (idx[7:6] == 2'h0) && (reg_stage != STAGE_NONE);
	assign reg_set   = set_idx(reg_stage, reg_group);

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= wb_req && !WB_ACK_O;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			WB_DAT_O <= 32'h0;
		end else if (wb_req && !WB_ACK_O) begin
			WB_DAT_O <= rdata;
		end
	end

	// --------------------------------------------------------------------
	// Setting banks
	// --------------------------------------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < NUM_SETS; i++) begin
				thr_mem[i]  <= THR_DEF;
				hyst_mem[i] <= HYST_DEF;
				op_mem[i]   <= OP_DEF;
			end
		end else if (wr_fire && in_set) begin
			unique case (reg_field)
				FLD_THR: begin
					thr_mem[reg_set] <= merge16(thr_mem[reg_set], WB_DAT_I, WB_SEL_I);
				end
				FLD_HYST: begin
					hyst_mem[reg_set] <= clamp_hyst(merge16(16'(hyst_mem[reg_set]),
						WB_DAT_I, WB_SEL_I));
				end
				FLD_OP: begin
					op_mem[reg_set] <= clamp_op(merge16(op_mem[reg_set], WB_DAT_I, WB_SEL_I),
						reg_stage);
				end
				FLD_REL: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			for (int g = 0; g < NUM_GROUPS; g++) begin
				rel_mem[g] <= REL_DEF;
			end
		end else if (wr_fire && in_set && reg_field == FLD_REL && reg_stage == 2'h0) begin
			rel_mem[reg_group] <= clamp_rel(merge16(rel_mem[reg_group], WB_DAT_I, WB_SEL_I));
		end
	end

	// --------------------------------------------------------------------
	// Stages
	// --------------------------------------------------------------------
	for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
		localparam logic [1:0] SI = 2'(s);
		tsov_stage #(
			.HAS_RELEASE (s == 0)
		) u_stage (
			.clk_i   (CLOCK_I),
			.rst_n_i (RST_N_I),
			.eval_i  (VOLT_VALID_I),
			.tick_i  (tick),
			.v_ab_i  (VOLT_AB_I),
			.v_bc_i  (VOLT_BC_I),
			.v_ca_i  (VOLT_CA_I),
			.thr_i   (thr_mem[set_idx(SI, grp_sync)]),
			.hyst_i  (hyst_mem[set_idx(SI, grp_sync)]),
			.op_i    (op_mem[set_idx(SI, grp_sync)]),
			.rel_i   (rel_mem[grp_sync]),
			.start_o (start_w[s]),
			.trip_o  (trip_w[s])
		);
	end

	assign START_O = start_w;
	assign TRIP_O  = trip_w;

	// --------------------------------------------------------------------
	// Events and interrupt
	// --------------------------------------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			start_prev <= '0;
			trip_prev  <= '0;
		end else begin
			start_prev <= start_w;
			trip_prev  <= trip_w;
		end
	end

	always_comb begin
		evt = '0;
		evt[STAT_START_LSB +: NUM_STAGES] = start_w & ~start_prev;
		evt[STAT_TRIP_LSB +: NUM_STAGES]  = trip_w & ~trip_prev;
		clr = '0;
		if (wr_fire && idx == IDX_STATUS && WB_SEL_I[0]) begin
			clr = WB_DAT_I[EVT_W-1:0];
		end
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			status <= '0;
		end else begin
			status <= (status & ~clr) | evt;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			mask <= '0;
		end else if (wr_fire && idx == IDX_MASK && WB_SEL_I[0]) begin
			mask <= WB_DAT_I[EVT_W-1:0];
		end
	end

	assign IRQ_O = |(status & mask);

	// --------------------------------------------------------------------
	// Read mux
	// --------------------------------------------------------------------
	always_comb begin
		rdata = 32'h0;
		if (in_set) begin
			unique case (reg_field)
				FLD_THR:  rdata = 32'(thr_mem[reg_set]);
				FLD_HYST: rdata = 32'(hyst_mem[reg_set]);
				FLD_OP:   rdata = 32'(op_mem[reg_set]);
				FLD_REL:  rdata = (reg_stage == 2'h0) ? 32'(rel_mem[reg_group]) : 32'h0;
			endcase
		end else begin
			unique case (idx)
				IDX_STATUS:  rdata = 32'(status);
				IDX_MASK:    rdata = 32'(mask);
				IDX_STATE: begin
					rdata[STAT_START_LSB +: NUM_STAGES] = start_w;
					rdata[STAT_TRIP_LSB +: NUM_STAGES]  = trip_w;
					rdata[STATE_GROUP_LSB +: 2]         = grp_sync;
				end
				IDX_VOLT_AB: rdata = 32'(volt_ab);
				IDX_VOLT_BC: rdata = 32'(volt_bc);
				IDX_VOLT_CA: rdata = 32'(volt_ca);
				default:     rdata = 32'h0;
			endcase
		end
	end

endmodule : tsov_top
`default_nettype wire
